/* core/cpm_port_master.sv */
// Top of the CPU-style parallel port master: settings, access sequencer and pins.
// Assumes synchronous inputs on clk and a testbench that resolves pins from enables.
`timescale 1ns/1ps
`default_nettype none
`include "cpm_cfg.svh"
module cpm_port_master #(
  parameter int SETUP_CYC  = `CPM_SETUP_CYC,
  parameter int STROBE_CYC = `CPM_STROBE_CYC,
  parameter int HOLD_CYC   = `CPM_HOLD_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [1:0]       modeSetting,
  input  wire logic [1:0]       protocolSetting,
  input  wire logic             readySourceSetting,
  input  wire logic             reqValid,
  input  wire cpm_pkg::cpm_req_t req,
  output var  logic             reqReady,
  output var  logic             done,
  output var  logic [15:0]      readData,
  output var  logic             badSetting,
  input  wire logic             irqIn,
  input  wire logic             irqClear,
  output var  logic             irqLatched,
  input  wire logic             portRstWrite,
  input  wire logic             portRstValue,
  input  wire logic             readyIn_n,
  input  wire logic [15:0]      dataIn,
  output var  cpm_pkg::cpm_pins_t pins
);
  import cpm_pkg::*;

  logic rstSync_n;
  logic latchedIrq;

  cpm_reset_sync uResetSync (
    .clk       (clk),
    .rst_n     (rst_n),
    .syncRst_n (rstSync_n)
  );

  cpm_irq_latch uIrq (
    .clk       (clk),
    .rstSync_n (rstSync_n),
    .irqIn     (irqIn),
    .clear     (irqClear),
    .latched   (latchedIrq)
  );

  cpm_state_t  state_ff;
  cpm_state_t  nxt_state;
  cpm_req_t    cur_ff;
  cpm_req_t    nxt_cur;
  logic [7:0]  count_ff;
  logic [7:0]  nxt_count;
  logic [15:0] readData_ff;
  logic [15:0] nxt_readData;
  logic        done_ff;
  logic        nxt_done;
  logic        reqReady_ff;
  logic        nxt_reqReady;
  logic        badSetting_ff;
  logic        nxt_badSetting;
  logic        portRst_ff;
  logic        nxt_portRst;
  logic        irqLatched_ff;
  cpm_pins_t   pins_ff;
  cpm_pins_t   nxt_pins;
  logic        master;
  logic        autoReady;

  // Turns a cycle count into the value loaded into the down counter.
  function automatic logic [7:0] loadCount(input int cycles);
    loadCount = (cycles < 1) ? 8'h00 : 8'(cycles - 1);
  endfunction

  // Only master mode with the single protocol runs cycles; any other code is off.
  assign master    = (modeSetting == `CPM_MODE_MASTER) &&
                     (protocolSetting == `CPM_PROTO_DEFAULT);
  assign autoReady = (readySourceSetting == `CPM_RDY_INSIDE);

  // Access sequencer: setup, strobe, optional wait, hold.
  always_comb begin
    nxt_state      = state_ff;
    nxt_cur        = cur_ff;
    nxt_count      = count_ff;
    nxt_readData   = readData_ff;
    nxt_done       = 1'b0;
    nxt_reqReady   = 1'b0;
    nxt_badSetting = !master && (modeSetting != `CPM_MODE_OFF);
    case (state_ff)
      CPM_IDLE: begin
        nxt_reqReady = master;
        if (reqValid && reqReady_ff && master) begin
          nxt_cur      = req;
          nxt_reqReady = 1'b0;
          nxt_count    = loadCount(SETUP_CYC);
          nxt_state    = CPM_SETUP;
        end
      end
      CPM_SETUP: begin
        if (count_ff == 8'h00) begin
          nxt_count = loadCount(STROBE_CYC);
          nxt_state = CPM_STROBE;
        end else begin
          nxt_count = count_ff - 8'h01;
        end
      end
      CPM_STROBE: begin
        if (count_ff != 8'h00) begin
          nxt_count = count_ff - 8'h01;
        end else if (autoReady) begin
          nxt_count = loadCount(HOLD_CYC);
          nxt_state = CPM_HOLD;
        end else begin
          nxt_state = CPM_WAIT;
        end
      end
      CPM_WAIT: begin
        // Waits here as long as the target holds ready back.
        if (!readyIn_n) begin
          nxt_count = loadCount(HOLD_CYC);
          nxt_state = CPM_HOLD;
        end
      end
      CPM_HOLD: begin
        if (count_ff == 8'h00) begin
          nxt_done  = 1'b1;
          nxt_state = CPM_IDLE;
        end else begin
          nxt_count = count_ff - 8'h01;
        end
      end
      default: begin
        nxt_state = CPM_IDLE;
      end
    endcase
    // Capture read data as the strobe ends; byte reads zero the upper half.
    if (!cur_ff.write && ((state_ff == CPM_STROBE && count_ff == 8'h00 && autoReady) ||
                          (state_ff == CPM_WAIT && !readyIn_n))) begin
      nxt_readData = cur_ff.word ? dataIn : {8'h00, dataIn[7:0]};
    end
    // Leaving master mode mid-cycle abandons it; pins float at once anyway.
    if (!master && state_ff != CPM_IDLE) begin
      nxt_state = CPM_IDLE;
      nxt_done  = 1'b1;
    end
  end

  // Reset output level simply follows the last software write.
  always_comb begin
    nxt_portRst = portRstWrite ? portRstValue : portRst_ff;
  end

  // Pin values, registered so every output comes from a flip-flop.
  always_comb begin
    logic busy;
    logic strobe;
    busy   = (nxt_state != CPM_IDLE);
    strobe = (nxt_state == CPM_STROBE) || (nxt_state == CPM_WAIT);
    nxt_pins           = '0;
    nxt_pins.addr      = busy ? nxt_cur.addr : 16'h0000;
    nxt_pins.dataOut   = nxt_cur.word ? nxt_cur.data : {8'h00, nxt_cur.data[7:0]};
    nxt_pins.dataOe    = master && busy && nxt_cur.write;
    nxt_pins.wrN       = !(strobe && nxt_cur.write);
    nxt_pins.rdN       = !(strobe && !nxt_cur.write);
    nxt_pins.selN[0]   = !(busy && !nxt_cur.target);
    nxt_pins.selN[1]   = !(busy && nxt_cur.target);
    nxt_pins.byteHighN = !(busy && nxt_cur.word);
    nxt_pins.portRstN  = nxt_portRst;
    nxt_pins.ctrlOe    = master;
  end

  // Registers of the sequencer and the pins; defaults leave the port off.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_ff      <= CPM_IDLE;
      cur_ff        <= '0;
      count_ff      <= 8'h00;
      readData_ff   <= 16'h0000;
      done_ff       <= 1'b0;
      reqReady_ff   <= 1'b0;
      badSetting_ff <= 1'b0;
      portRst_ff    <= `CPM_PORT_RST_RESET;
      irqLatched_ff <= 1'b0;
      pins_ff       <= '{addr: 16'h0000, dataOut: 16'h0000, dataOe: 1'b0, rdN: 1'b1, wrN: 1'b1,
                         selN: 2'h3, byteHighN: 1'b1, portRstN: 1'b1, ctrlOe: 1'b0};
    end else begin
      state_ff      <= nxt_state;
      cur_ff        <= nxt_cur;
      count_ff      <= nxt_count;
      readData_ff   <= nxt_readData;
      done_ff       <= nxt_done;
      reqReady_ff   <= nxt_reqReady;
      badSetting_ff <= nxt_badSetting;
      portRst_ff    <= nxt_portRst;
      irqLatched_ff <= latchedIrq;
      pins_ff       <= nxt_pins;
    end
  end

  assign reqReady   = reqReady_ff;
  assign done       = done_ff;
  assign readData   = readData_ff;
  assign badSetting = badSetting_ff;
  assign irqLatched = irqLatched_ff;
  assign pins       = pins_ff;
endmodule
`default_nettype wire

/* core/cpm_cfg.svh */
// Constants for the CPU-style parallel port master: codes, widths and timing counts.
// Assumes inclusion by the top port master module only; definitions only.
// What this block does
// - Mode 0 master, 2 off; off floats outputs.
// - Only protocol code 0, the default.
// - Ready source 0 outside, 1 inside (default).
// - Write drives address and data, then strobes.
// - Read drives address, strobes, captures returned data.
// - Assert select line of chosen target 0/1.
// - Sixteen-bit address bus covers 64k space.
// - Per-access byte or word width only.
// - Latch interrupt line, readable as one bit.
// - Software clear resets the interrupt latch.
// - Reset output follows last software-written level.
`ifndef CPM_CFG_SVH
`define CPM_CFG_SVH
`define CPM_MODE_MASTER     2'h0
`define CPM_MODE_OFF        2'h2
`define CPM_MODE_RESET      2'h2
`define CPM_PROTO_DEFAULT   2'h0
`define CPM_RDY_OUTSIDE     1'h0
`define CPM_RDY_INSIDE      1'h1
`define CPM_RDY_RESET       1'h1
`define CPM_PORT_RST_RESET  1'h1
`define CPM_CLK_MHZ         40
`define CPM_SETUP_NS        50
`define CPM_STROBE_NS       100
`define CPM_HOLD_NS         25
`define CPM_SETUP_CYC       ((`CPM_SETUP_NS * `CPM_CLK_MHZ + 999) / 1000)
`define CPM_STROBE_CYC      ((`CPM_STROBE_NS * `CPM_CLK_MHZ + 999) / 1000)
`define CPM_HOLD_CYC        ((`CPM_HOLD_NS * `CPM_CLK_MHZ + 999) / 1000)
`endif

/* core/cpm_pkg.sv */
// Types shared by the port master modules.
// Assumes cpm_cfg.svh is reachable on the include path.
package cpm_pkg;
  typedef enum logic [2:0] {
    CPM_IDLE   = 3'b000,
    CPM_SETUP  = 3'b001,
    CPM_STROBE = 3'b010,
    CPM_WAIT   = 3'b011,
    CPM_HOLD   = 3'b100
  } cpm_state_t;

  // One access request from software.
  typedef struct packed {
    logic        write;
    logic        target;
    logic        word;
    logic [15:0] addr;
    logic [15:0] data;
  } cpm_req_t;

  // Port pins driven by the master; dataOe enables the data lines, ctrlOe the others.
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] dataOut;
    logic        dataOe;
    logic        rdN;
    logic        wrN;
    logic [1:0]  selN;
    logic        byteHighN;
    logic        portRstN;
    logic        ctrlOe;
  } cpm_pins_t;
endpackage

/* core/cpm_reset_sync.sv */
// Reset release synchroniser: asserts at once, releases after two clock edges.
// Assumes rst_n may be asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module cpm_reset_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  output var  logic syncRst_n
);
  logic stage1_ff;
  logic stage2_ff;

  // The first stage feeds only the second, so a metastable release cannot fan out.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end else begin
      stage1_ff <= 1'b1;
      stage2_ff <= stage1_ff;
    end
  end
  assign syncRst_n = stage2_ff;
endmodule
`default_nettype wire

/* core/cpm_irq_latch.sv */
// Interrupt latch for the port's incoming interrupt line.
// Assumes the line is synchronous to clk and active high here.
`timescale 1ns/1ps
`default_nettype none
module cpm_irq_latch (
  input  wire logic clk,
  input  wire logic rstSync_n,
  input  wire logic irqIn,
  input  wire logic clear,
  output var  logic latched
);
  logic latched_ff;
  logic nxt_latched;

  // A set in the same cycle as a clear wins, so no interrupt is lost.
  always_comb begin
    nxt_latched = latched_ff;
    if (clear) begin
      nxt_latched = 1'b0;
    end
    if (irqIn) begin
      nxt_latched = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      latched_ff <= 1'b0;
    end else begin
      latched_ff <= nxt_latched;
    end
  end
  assign latched = latched_ff;
endmodule
`default_nettype wire

/* tb/cpm_port_master_chk.sv */
// Checker for the port master: strobe timing, select, address and latch relations.
// Assumes the default 2/4/1 counts and settings held steady during an access.
`timescale 1ns/1ps
`default_nettype none
module cpm_port_master_chk (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic [1:0]         modeSetting,
  input wire logic               readySourceSetting,
  input wire logic               reqValid,
  input wire cpm_pkg::cpm_req_t  req,
  input wire logic               reqReady,
  input wire logic               done,
  input wire logic               irqIn,
  input wire logic               irqClear,
  input wire logic               irqLatched,
  input wire logic               portRstWrite,
  input wire logic               portRstValue,
  input wire logic               readyIn_n,
  input wire cpm_pkg::cpm_pins_t pins
);
  import cpm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // An access starts on the edge where master mode meets a valid request.
  wire take = reqValid && reqReady && modeSetting == 2'h0;
  wire stb = !pins.rdN || !pins.wrN;
  wire inr = take && readySourceSetting;
  AST_OFF_FLOAT: assert property (modeSetting == 2'h2 [*3] |-> !pins.ctrlOe && !pins.dataOe)
    else $error("pins driven while off");
  AST_DONE_INT: assert property (inr |=> !done [*7] ##1 done)
    else $error("internal ready length");
  AST_WR: assert property (inr && req.write |-> ##3 (!pins.wrN && pins.rdN) [*4] ##1 pins.wrN)
    else $error("write strobe");
  AST_RD: assert property (inr && !req.write |-> ##3 (!pins.rdN && pins.wrN) [*4] ##1 pins.rdN)
    else $error("read strobe");
  AST_SEL: assert property (take |=> !pins.selN[$past(req.target)] && pins.selN[!$past(req.target)])
    else $error("select line");
  AST_ADDR: assert property (take |=> pins.ctrlOe && pins.addr == $past(req.addr))
    else $error("address lines");
  AST_WIDTH: assert property (take |=> pins.byteHighN == !$past(req.word))
    else $error("width line");
  AST_IRQ: assert property (irqIn |=> ##1 irqLatched)
    else $error("interrupt not latched");
  AST_CLR: assert property (irqClear && !irqIn ##1 !irqIn |=> !irqLatched)
    else $error("interrupt not cleared");
  AST_PRST: assert property (portRstWrite && modeSetting == 2'h0 |=> pins.portRstN == $past(portRstValue))
    else $error("port reset level");
  AST_WAIT: assert property (!readySourceSetting && stb && readyIn_n |=> stb)
    else $error("strobe ended early");
  COV_WR: cover property (take && req.write);
  COV_EXT: cover property (take && !readySourceSetting);
  COV_CLR: cover property (irqClear && irqLatched);
endmodule
bind cpm_port_master cpm_port_master_chk cpm_port_master_chk_inst (.clk(clk), .rst_n(rst_n),
  .modeSetting(modeSetting), .readySourceSetting(readySourceSetting), .reqValid(reqValid), .req(req),
  .reqReady(reqReady), .done(done), .irqIn(irqIn), .irqClear(irqClear), .irqLatched(irqLatched),
  .portRstWrite(portRstWrite), .portRstValue(portRstValue), .readyIn_n(readyIn_n), .pins(pins));
`default_nettype wire

/* tb/cpm_target_model.sv */
// Two small targets on the port: four words each, ready after waitCyc strobe cycles.
// Assumes the master's pins; returns inverted stale data when not being read.
`timescale 1ns/1ps
`default_nettype none
module cpm_target_model (
  input  wire logic               clk,
  input  wire cpm_pkg::cpm_pins_t pins,
  input  wire logic [3:0]         waitCyc,
  output var  logic               readyIn_n,
  output var  logic [15:0]        dataIn
);
  import cpm_pkg::*;
  logic [15:0] mem [2][4];
  logic [3:0]  cnt = 4'h0;
  logic [15:0] last = 16'h5A5A;
  wire         tgt = pins.selN[0];
  wire         stb = !pins.rdN || !pins.wrN;
  // Byte writes clear the upper half, so a word read shows what width arrived.
  always_ff @(posedge clk) begin
    cnt <= stb ? cnt + 4'h1 : 4'h0;
    if (!pins.wrN) mem[tgt][pins.addr[1:0]] <= pins.byteHighN ? {8'h00, pins.dataOut[7:0]} : pins.dataOut;
    if (!pins.rdN) last <= dataIn;
  end
  // Ready comes late on purpose; a released bus shows the inverted last read value.
  always_comb begin
    readyIn_n = !(stb && cnt >= waitCyc);
    dataIn = (!pins.rdN && pins.selN != 2'h3) ? mem[tgt][pins.addr[1:0]] : ~last;
  end
endmodule
`default_nettype wire

/* tb/cpm_port_master_test.sv */
// Testbench for the port master: drives settings and requests, judges pins and results.
// Assumes the package, the target model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cpm_port_master_test;
  import cpm_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  modeSetting = 2'h2;
  logic [1:0]  protocolSetting = 2'h0;
  logic        readySourceSetting = 1'b1;
  logic        reqValid = 1'b0;
  cpm_req_t    req = '0;
  logic        irqIn = 1'b0;
  logic        irqClear = 1'b0;
  logic        portRstWrite = 1'b0;
  logic        portRstValue = 1'b1;
  logic [3:0]  waitCyc = 4'h0;
  logic        reqReady, done, badSetting, irqLatched, readyIn_n;
  logic [15:0] readData, dataIn;
  cpm_pins_t   pins;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n;
  // Half period of the 40 MHz clock.
  always #12.5 clk = ~clk;
  cpm_port_master cpm_port_master_inst (.clk(clk), .rst_n(rst_n), .modeSetting(modeSetting),
    .protocolSetting(protocolSetting), .readySourceSetting(readySourceSetting), .reqValid(reqValid),
    .req(req), .reqReady(reqReady), .done(done), .readData(readData), .badSetting(badSetting),
    .irqIn(irqIn), .irqClear(irqClear), .irqLatched(irqLatched), .portRstWrite(portRstWrite),
    .portRstValue(portRstValue), .readyIn_n(readyIn_n), .dataIn(dataIn), .pins(pins));
  cpm_target_model cpm_target_model_inst (.clk(clk), .pins(pins), .waitCyc(waitCyc),
    .readyIn_n(readyIn_n), .dataIn(dataIn));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Bounded wait on falling edges, so a hung handshake ends the run instead of the sim.
  task automatic waitHi(ref logic s, input int lim, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (s !== 1'b1 && c < lim);
    if (s !== 1'b1) begin
      chk(1'b0, "handshake timeout");
      complete_run();
    end
  endtask
  // One whole access: request held until taken, then released; read data judged at done.
  task automatic acc(input logic w, t, wd, input logic [15:0] a, d, exp, output int c);
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{w, t, wd, a, d};
    waitHi(reqReady, 20, c);
    @(posedge clk);
    reqValid <= 1'b0;
    waitHi(done, 40, c);
    if (!w) chk(readData === exp, "read data");
  endtask
  task automatic t_off();
    repeat (4) @(posedge clk);
    chk(pins.ctrlOe === 1'b0 && reqReady === 1'b0 && badSetting === 1'b0, "off port active");
    modeSetting <= 2'h0;
    protocolSetting <= 2'h1;
    repeat (4) @(posedge clk);
    chk(reqReady === 1'b0, "bad protocol accepted");
    protocolSetting <= 2'h0;
    modeSetting <= 2'h1;
    repeat (4) @(posedge clk);
    chk(reqReady === 1'b0 && badSetting === 1'b1, "illegal mode not flagged");
    modeSetting <= 2'h0;
    $display("test off ended");
  endtask
  task automatic t_acc();
    acc(1'b1, 1'b0, 1'b1, 16'hFFFF, 16'hA5C3, 16'h0000, n);
    acc(1'b1, 1'b1, 1'b1, 16'h0000, 16'h3C5A, 16'h0000, n);
    acc(1'b0, 1'b0, 1'b1, 16'hFFFF, 16'h0000, 16'hA5C3, n);
    chk(n == 8, "internal ready length");
    acc(1'b0, 1'b1, 1'b1, 16'h0000, 16'h0000, 16'h3C5A, n);
    acc(1'b0, 1'b0, 1'b0, 16'hFFFF, 16'h0000, 16'h00C3, n);
    @(posedge clk);
    readySourceSetting <= 1'b0;
    waitCyc <= 4'h9;
    acc(1'b0, 1'b1, 1'b1, 16'h0000, 16'h0000, 16'h3C5A, n);
    chk(n > 8, "no wait states");
    @(posedge clk);
    readySourceSetting <= 1'b1;
    $display("test access ended");
  endtask
  task automatic t_side();
    @(posedge clk);
    irqIn <= 1'b1;
    @(posedge clk);
    irqIn <= 1'b0;
    repeat (3) @(posedge clk);
    chk(irqLatched === 1'b1, "latch lost");
    irqClear <= 1'b1;
    @(posedge clk);
    irqClear <= 1'b0;
    repeat (2) @(posedge clk);
    chk(irqLatched === 1'b0, "latch stuck");
    for (int v = 0; v < 2; v++) begin
      portRstWrite <= 1'b1;
      portRstValue <= v[0];
      @(posedge clk);
      portRstWrite <= 1'b0;
      repeat (2) @(posedge clk);
      chk(pins.portRstN === v[0], "reset output");
    end
    $display("test side ended");
  endtask
  // Reset held 16 cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_off();
    t_acc();
    t_side();
    complete_run();
  end
endmodule
`default_nettype wire
